// ---- design/csd_pkg.sv ----
package csd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indices; bus byte address is four times the index
  localparam logic [7:0] IDX_PTR_A_LO  = 8'h82;
  localparam logic [7:0] IDX_PTR_A_HI  = 8'h83;
  localparam logic [7:0] IDX_PTR_B_LO  = 8'h84;
  localparam logic [7:0] IDX_PTR_B_HI  = 8'h85;
  localparam logic [7:0] IDX_CHOICE    = 8'h86;
  localparam logic [7:0] IDX_CLKCTL    = 8'h8E;
  localparam logic [7:0] IDX_PROTECT   = 8'h90;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_PTR_BYTE  = 8'h00;
  localparam logic       RST_CHOICE    = 1'b0;
  localparam logic [5:0] RST_CLKCTL    = 6'h01;   // stretch 1, all timers slow
  localparam logic       RST_PROTECT   = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int STRETCH_LSB   = 0;
  localparam int STRETCH_W     = 3;
  localparam int RATE_LSB      = 3;               // timer 0 at 3, 1 at 4, 2 at 5
  localparam int NUM_TIMERS    = 3;
  localparam int CLKCTL_W      = 6;
  localparam int CHOICE_SEL    = 0;
  localparam int PROTECT_BIT   = 0;

  //////////////////////////////////////////////////////////////////////////////
  // timing counts in clocks or instruction cycles
  localparam int MC_CLOCKS     = 4;               // fast bus cycle
  localparam int CLASSIC_CLKS  = 12;              // classic bus cycle
  localparam int MOVX_BASE     = 2;               // unstretched move length

  //////////////////////////////////////////////////////////////////////////////
  // core-side request and status carriers
  typedef struct packed {
    logic active_data_pointer_inc;                               // increment active pointer
    logic choice_inc;                             // increment pointer choice
    logic movx_start;                             // begin external data move
  } csd_core_req_s;

  typedef struct packed {
    logic movx_busy;                              // data move in progress
    logic movx_done;                              // data move finished
    logic mc_strobe;                              // end of a bus cycle
    logic fetch_strobe;                           // program fetch slot
  } csd_core_stat_s;

endpackage

// ---- design/csd_rate_tick.sv ----
`timescale 1ns/1ps
module csd_rate_tick
  import csd_pkg::*;
#(
  parameter int FAST_CLKS = MC_CLOCKS,
  parameter int SLOW_CLKS = CLASSIC_CLKS
) (
  input  wire logic hclk,     // core clock
  input  wire logic hresetn,  // async reset, low active
  input  wire logic clk_en,   // freezes counting when low
  input  wire logic fast,     // one selects fast rate
  output logic      tick_q    // one-cycle timer count pulse
);

  logic [3:0] cnt_q;
  logic [3:0] lim;

  // limit follows the rate bit at once; >= keeps a shrink mid-count safe
  assign lim = fast ? 4'(FAST_CLKS - 1) : 4'(SLOW_CLKS - 1);

  //////////////////////////////////////////////////////////////////////////////
  // divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q >= lim) begin
        cnt_q  <= 4'h0;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 4'h1;
        tick_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);

  // a rate write back to slow may stretch the gap, so a dropped rate bit ends the check
  AST_TICK_FAST: assert property (tick_q && fast |=> (!tick_q || !fast) [*3] ##1 (tick_q || !fast))
    else $error("fast timer tick period is not four clocks");
  AST_TICK_BOUND: assert property (!fast |-> cnt_q <= 4'(SLOW_CLKS - 1))
    else $error("slow timer divider passed twelve clocks");
  COV_FAST_TICK: cover property (fast && tick_q);

endmodule

// ---- design/csd_core.sv ----
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - The core completes each bus cycle in four clocks rather than twelve.
// - An external data move takes at least two instruction cycles with no stretch.
// - The low three bits of the clock control register at 8Eh hold the stretch value 0 to 7.
// - Each stretch unit adds one instruction cycle, so seven gives a nine-cycle move.
// - Software may rewrite the stretch value at any time, with no reset needed.
// - After reset the stretch reads one, giving three-cycle moves.
// - The stretch lengthens only data moves, never program fetch timing.
// - The first data pointer sits at 82h low byte and 83h high byte.
// - The second data pointer sits at 84h low byte and 85h high byte.
// - Bit 0 of the choice register at 86h picks the first (0) or second (1) pointer.
// - The other seven bits of the choice register do nothing and read zero.
// - Incrementing the choice register toggles bit 0 and so swaps pointers.
// - After reset the timers count once per twelve clocks.
// - A set timer rate bit gives four clocks per count, a clear one twelve; each resets to zero.
// - Clock control bits 5, 4 and 3 set timers 2, 1 and 0 independently.
// - Program memory cannot be read from outside until a mass erase.
module csd_core
  import csd_pkg::*;
(
  input  wire logic           hclk,              // core clock
  input  wire logic           hresetn,           // async reset, low active
  input  wire logic           clk_en,            // freezes block state when low, except bus reads and register writes
  input  wire logic           hsel,              // slave select
  input  wire logic [31:0]    haddr,             // byte address
  input  wire logic [1:0]     htrans,            // transfer type
  input  wire logic           hwrite,            // write when high
  input  wire logic [2:0]     hsize,             // word only
  input  wire logic [31:0]    hwdata,            // write data
  input  wire logic           hready,            // bus ready
  output logic                hreadyout,         // slave ready
  output logic [31:0]         hrdata,            // read data
  output logic                hresp,             // always okay
  input  wire csd_core_req_s  core_req,          // core requests
  input  wire logic           mass_erase_done,   // flash erased pulse
  input  wire logic           code_rd_req,       // outside program read
  input  wire logic [7:0]     flash_rd_data,     // raw flash byte
  output csd_core_stat_s      core_stat,         // bus and move timing
  output logic [15:0]         active_data_pointer, // selected pointer
  output logic [2:0]          timer_tick,        // per-timer count pulses
  output logic [7:0]          code_rd_data,      // guarded program byte
  output logic                code_protected     // program read blocked
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0]          ptr_a_q, ptr_a_d;        // first_data_pointer
  logic [15:0]          ptr_b_q, ptr_b_d;        // second_data_pointer
  logic                 choice_q, choice_d;      // pointer_choice_register bit 0
  logic [CLKCTL_W-1:0]  clkctl_q, clkctl_d;      // core_clock_control_register
  logic                 protect_q;
  logic [1:0]           phase_q;
  logic                 busy_q;
  logic [5:0]           mcnt_q;
  logic [3:0]           movx_total_q;
  logic                 wr_pend_q;
  logic [7:0]           wr_idx_q;
  logic [15:0]          active_q;
  logic                 mc_strobe_q;             // end of each bus cycle
  logic                 fetch_strobe_q;          // program fetch slot
  logic                 movx_done_q;             // one pulse as a move ends
  logic [31:0]          hrdata_q;
  logic [7:0]           code_q;

  logic                 acc;
  logic                 mapped;
  logic [7:0]           a_idx;
  logic                 movx_go;
  logic [3:0]           movx_total_d;
  logic [NUM_TIMERS-1:0] tick_w;

  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = hrdata_q;
  // status fields are separate flops so that each process owns its own bits
  assign core_stat           = '{movx_busy:    busy_q,
                                 movx_done:    movx_done_q,
                                 mc_strobe:    mc_strobe_q,
                                 fetch_strobe: fetch_strobe_q};
  assign active_data_pointer = active_q;
  assign code_rd_data        = code_q;
  assign code_protected      = protect_q;

  //////////////////////////////////////////////////////////////////////////////
  // bus address phase decode; unmapped reads zero, writes dropped
  assign a_idx  = haddr[9:2];
  assign acc    = hsel && htrans[1] && hready;
  // narrow transfers fall outside the map rather than tear a register
  assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);

  function automatic logic [31:0] rd_value(input logic [7:0] idx);
    logic [31:0] v;
    v = 32'h0;
    case (idx)
      IDX_PTR_A_LO: v[7:0]          = ptr_a_q[7:0];
      IDX_PTR_A_HI: v[7:0]          = ptr_a_q[15:8];
      IDX_PTR_B_LO: v[7:0]          = ptr_b_q[7:0];
      IDX_PTR_B_HI: v[7:0]          = ptr_b_q[15:8];
      IDX_CHOICE:   v[CHOICE_SEL]   = choice_q;
      IDX_CLKCTL:   v[CLKCTL_W-1:0] = clkctl_q;
      IDX_PROTECT:  v[PROTECT_BIT]  = protect_q;
      default:      v               = 32'h0;
    endcase
    return v;
  endfunction

  // bus logic stays live while clk_en is low so software is never stalled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      hrdata_q  <= 32'h0;
    end else begin
      wr_pend_q <= acc && hwrite && mapped;
      wr_idx_q  <= a_idx;
      if (acc && !hwrite) begin
        hrdata_q <= mapped ? rd_value(a_idx) : 32'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register next state: core ops first, a bus write in the same cycle wins
  always_comb begin
    ptr_a_d  = ptr_a_q;
    ptr_b_d  = ptr_b_q;
    choice_d = choice_q;
    clkctl_d = clkctl_q;
    if (clk_en && core_req.active_data_pointer_inc) begin
      if (choice_q) begin
        ptr_b_d = ptr_b_q + 16'h1;
      end else begin
        ptr_a_d = ptr_a_q + 16'h1;
      end
    end
    if (clk_en && core_req.choice_inc) begin
      choice_d = ~choice_q;
    end
    if (wr_pend_q) begin
      case (wr_idx_q)
        IDX_PTR_A_LO: ptr_a_d[7:0]  = hwdata[7:0];
        IDX_PTR_A_HI: ptr_a_d[15:8] = hwdata[7:0];
        IDX_PTR_B_LO: ptr_b_d[7:0]  = hwdata[7:0];
        IDX_PTR_B_HI: ptr_b_d[15:8] = hwdata[7:0];
        IDX_CHOICE:   choice_d      = hwdata[CHOICE_SEL];
        IDX_CLKCTL:   clkctl_d      = hwdata[CLKCTL_W-1:0];
        default:      ;
      endcase
    end
  end

  // register flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_a_q  <= {RST_PTR_BYTE, RST_PTR_BYTE};
      ptr_b_q  <= {RST_PTR_BYTE, RST_PTR_BYTE};
      choice_q <= RST_CHOICE;
      clkctl_q <= RST_CLKCTL;
      active_q <= {RST_PTR_BYTE, RST_PTR_BYTE};
    end else begin
      ptr_a_q  <= ptr_a_d;
      ptr_b_q  <= ptr_b_d;
      choice_q <= choice_d;
      clkctl_q <= clkctl_d;
      active_q <= choice_d ? ptr_b_d : ptr_a_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus cycle phase; fetch slot never sees the stretch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q        <= 2'h0;
      mc_strobe_q    <= 1'b0;
      fetch_strobe_q <= 1'b0;
    end else if (clk_en) begin
      phase_q        <= phase_q + 2'h1;
      mc_strobe_q    <= phase_q == 2'(MC_CLOCKS - 1);
      fetch_strobe_q <= phase_q == 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data move sequencer; length latched at start
  assign movx_go      = clk_en && core_req.movx_start && !busy_q;
  assign movx_total_d = 4'(MOVX_BASE) + {1'b0, clkctl_q[STRETCH_LSB +: STRETCH_W]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q       <= 1'b0;
      mcnt_q       <= 6'h0;
      movx_total_q <= 4'h0;
      movx_done_q  <= 1'b0;
    end else if (clk_en) begin
      movx_done_q <= 1'b0;
      if (movx_go) begin
        busy_q       <= 1'b1;
        movx_total_q <= movx_total_d;
        mcnt_q       <= 6'(int'(movx_total_d) * MC_CLOCKS - 1);
      end else if (busy_q) begin
        if (mcnt_q == 6'h0) begin
          busy_q      <= 1'b0;
          movx_done_q <= 1'b1;
        end else begin
          mcnt_q <= mcnt_q - 6'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-timer rate dividers
  generate
    for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
      csd_rate_tick u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_en  (clk_en),
        .fast    (clkctl_q[RATE_LSB + t]),
        .tick_q  (tick_w[t])
      );
    end
  endgenerate

  assign timer_tick = tick_w;

  //////////////////////////////////////////////////////////////////////////////
  // code read guard; only a mass erase lifts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      protect_q <= RST_PROTECT;
      code_q    <= 8'h00;
    end else if (clk_en) begin
      if (mass_erase_done) begin
        protect_q <= 1'b0;
      end
      if (code_rd_req) begin
        code_q <= protect_q ? 8'h00 : flash_rd_data;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks; helper counts clocks of each move
  logic [5:0] busy_len_q;
  logic       rd_choice_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_len_q  <= 6'h0;
      rd_choice_q <= 1'b0;
    end else begin
      rd_choice_q <= acc && !hwrite && mapped && (a_idx == IDX_CHOICE);
      if (clk_en) begin
        busy_len_q <= movx_go ? 6'h0 : (busy_q ? busy_len_q + 6'h1 : busy_len_q);
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);

  //////////////////////////////////////////////////////////////////////////////
  // bus cycle and fetch slot timing
  AST_MC_PERIOD: assert property (mc_strobe_q |=> !mc_strobe_q [*3] ##1 mc_strobe_q)
    else $error("bus cycle is not four clocks");
  AST_FETCH_FIXED: assert property (fetch_strobe_q |=> !fetch_strobe_q [*3] ##1 fetch_strobe_q)
    else $error("fetch slot period disturbed");
  // the fetch slot trails every bus cycle end, whether a move is busy or not
  AST_FETCH_AFTER_MC: assert property (mc_strobe_q |=> fetch_strobe_q)
    else $error("fetch slot did not follow bus cycle end");

  //////////////////////////////////////////////////////////////////////////////
  // data move length and stretch latching
  AST_MOVX_LEN: assert property (movx_done_q |-> busy_len_q == 6'(int'(movx_total_q) * MC_CLOCKS))
    else $error("data move length does not match latched stretch");
  AST_MOVX_MIN: assert property ($rose(busy_q) |-> busy_q [*8])
    else $error("data move shorter than two instruction cycles");
  // the widest stretch bounds every move, whatever was written meanwhile
  AST_MOVX_MAX: assert property (busy_q |-> busy_len_q < 6'((MOVX_BASE + (1 << STRETCH_W) - 1) * MC_CLOCKS))
    else $error("data move longer than nine instruction cycles");
  AST_DONE_PULSE: assert property (movx_done_q |=> !movx_done_q)
    else $error("move done held longer than one clock");
  AST_STRETCH_HOLD: assert property (busy_q && !movx_go |=> $stable(movx_total_q))
    else $error("stretch changed during a move");

  //////////////////////////////////////////////////////////////////////////////
  // register writes, reset values and pointer selection
  AST_STRETCH_RST: assert property (disable iff (1'b0) $rose(hresetn) |-> clkctl_q == RST_CLKCTL)
    else $error("clock control reset value wrong");
  AST_CLKCTL_WRITE: assert property (wr_pend_q && wr_idx_q == IDX_CLKCTL |=>
                                     clkctl_q == $past(hwdata[CLKCTL_W-1:0]))
    else $error("clock control write did not take");
  AST_CHOICE_TOGGLE: assert property (core_req.choice_inc && !wr_pend_q |=> choice_q != $past(choice_q))
    else $error("choice increment did not toggle");
  AST_CHOICE_WRITE: assert property (wr_pend_q && wr_idx_q == IDX_CHOICE |=>
                                     choice_q == $past(hwdata[CHOICE_SEL]))
    else $error("choice write did not take");
  AST_CHOICE_ZERO: assert property (disable iff (!hresetn) rd_choice_q |-> hrdata_q[31:1] == 31'h0)
    else $error("unused choice bits read nonzero");
  AST_ACTIVE_PTR: assert property (##1 active_q == (choice_q ? ptr_b_q : ptr_a_q))
    else $error("active pointer does not follow choice");
  // an increment must move the selected pointer by one and leave the other alone
  AST_ACTIVE_DATA_POINTER_INC_A: assert property (core_req.active_data_pointer_inc && !choice_q && !wr_pend_q |=>
                                   ptr_a_q == $past(ptr_a_q) + 16'h1 && ptr_b_q == $past(ptr_b_q))
    else $error("first pointer increment went wrong");
  AST_ACTIVE_DATA_POINTER_INC_B: assert property (core_req.active_data_pointer_inc && choice_q && !wr_pend_q |=>
                                   ptr_b_q == $past(ptr_b_q) + 16'h1 && ptr_a_q == $past(ptr_a_q))
    else $error("second pointer increment went wrong");

  //////////////////////////////////////////////////////////////////////////////
  // program read guard
  AST_PROTECT: assert property (protect_q && code_rd_req |=> code_q == 8'h00)
    else $error("protected program byte leaked");
  // nothing but an erase may lift the guard; bus writes to it are dropped
  AST_PROTECT_HOLD: assert property (protect_q && !mass_erase_done |=> protect_q)
    else $error("program guard lifted without an erase");

  COV_MOVX_MAX: cover property (movx_done_q && movx_total_q == 4'h9);
  COV_CHOICE_SWAP: cover property (core_req.choice_inc && choice_q);
  COV_ERASE_READ: cover property (!protect_q && code_rd_req);
  COV_FROZEN_INC: cover property (disable iff (!hresetn) !clk_en && core_req.active_data_pointer_inc);

endmodule

// ---- test/tb_csd_core.sv ----
`timescale 1ns/1ps
module tb_csd_core
  import csd_pkg::*;
;
  localparam int LIMIT = 20000;   // cycles; whole sequence needs well under a thousand

  logic           hclk;
  logic           hresetn;
  logic           clk_en;
  logic           hsel;
  logic [31:0]    haddr;
  logic [1:0]     htrans;
  logic           hwrite;
  logic [2:0]     hsize;
  logic [31:0]    hwdata;
  logic           hready;
  logic           hreadyout;
  logic [31:0]    hrdata;
  logic           hresp;
  csd_core_req_s  core_req;
  logic           mass_erase_done;
  logic           code_rd_req;
  logic [7:0]     flash_rd_data;
  csd_core_stat_s core_stat;
  logic [15:0]    adp;
  logic [2:0]     timer_tick;
  logic [7:0]     code_rd_data;
  logic           code_protected;
  logic [4:0]     pulses;
  int             failures;
  int             n_checks;
  int             cyc;
  int             p;
  logic [7:0]     q8;

  //////////////////////////////////////////////////////////////////////////////
  // one slave, so its ready is the bus ready
  assign hready = hreadyout;
  assign pulses = {core_stat.mc_strobe, core_stat.fetch_strobe, timer_tick};

  csd_core csd_core_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_req(core_req),
    .mass_erase_done(mass_erase_done), .code_rd_req(code_rd_req), .flash_rd_data(flash_rd_data),
    .core_stat(core_stat), .active_data_pointer(adp), .timer_tick(timer_tick),
    .code_rd_data(code_rd_data), .code_protected(code_protected));

  //////////////////////////////////////////////////////////////////////////////
  // 4 ns clock; cycle count doubles as hang guard
  always #2 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      results();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // comparisons and verdict
  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_int(string nm, int e, int g);
    n_checks++;
    if (g != e) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // bus single transfer; waits on ready, never on a fixed count
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= we;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(string nm, logic [7:0] idx, logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, idx, 8'h00, q);
    chk_word(nm, e, q);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // core side stimulus and timing probes
  task automatic pulse(logic [2:0] r);
    core_req <= r;
    @(posedge hclk);
    core_req <= 3'h0;
  endtask

  // skips the first gap, since a rate change may leave it short
  task automatic period(int sel, output int per);
    int t;
    t = 0;
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      while (pulses[sel] !== 1'b1) @(posedge hclk);
      if (k == 1) t = cyc;
    end
    per = cyc - t;
  endtask

  // mid 1 rewrites stretch in flight, mid 2 probes fetch timing in flight
  task automatic movx(int s, int mid);
    int t0;
    int fp;
    t0 = cyc;
    pulse(3'h1);
    if (mid == 1) wr(IDX_CLKCTL, 8'h03);
    if (mid == 2) begin
      period(3, fp);
      chk_int("fetch period in move", MC_CLOCKS, fp);
    end
    // one edge takes the start, one more sees the done pulse after the busy clocks
    while (core_stat.movx_done !== 1'b1) @(posedge hclk);
    chk_int("move length", (MOVX_BASE + s) * MC_CLOCKS + 2, cyc - t0);
  endtask

  task automatic code_rd(output logic [7:0] q);
    code_rd_req <= 1'b1;
    @(posedge hclk);
    code_rd_req <= 1'b0;
    @(posedge hclk);
    q = code_rd_data;
  endtask

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hclk = 1'b0; hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; core_req = 3'h0; mass_erase_done = 1'b0;
    code_rd_req = 1'b0; flash_rd_data = 8'hA5; failures = 0; n_checks = 0; cyc = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("clkctl reset", IDX_CLKCTL, 32'h00000001);
    rd_chk("choice reset", IDX_CHOICE, 32'h00000000);
    for (int t = 0; t < NUM_TIMERS; t++) begin
      period(t, p);
      chk_int("timer period reset", CLASSIC_CLKS, p);
    end
    period(4, p);
    chk_int("bus cycle period", MC_CLOCKS, p);
    movx(1, 0);
    wr(IDX_CLKCTL, 8'h00);
    movx(0, 1);
    movx(3, 0);
    wr(IDX_CLKCTL, 8'h07);
    rd_chk("stretch max", IDX_CLKCTL, 32'h00000007);
    movx(7, 2);
    // one fast bit at a time shows the rates do not couple
    for (int t = 0; t < NUM_TIMERS; t++) begin
      wr(IDX_CLKCTL, 8'h08 << t);
      for (int u = 0; u < NUM_TIMERS; u++) begin
        period(u, p);
        chk_int("timer period", (u == t) ? MC_CLOCKS : CLASSIC_CLKS, p);
      end
    end
    wr(IDX_PTR_A_LO, 8'h11);
    wr(IDX_PTR_A_HI, 8'h22);
    wr(IDX_PTR_B_LO, 8'hFF);
    wr(IDX_PTR_B_HI, 8'h12);
    rd_chk("ptr a low", IDX_PTR_A_LO, 32'h00000011);
    rd_chk("ptr a high", IDX_PTR_A_HI, 32'h00000022);
    rd_chk("ptr b low", IDX_PTR_B_LO, 32'h000000FF);
    rd_chk("ptr b high", IDX_PTR_B_HI, 32'h00000012);
    chk_word("active ptr first", 32'h00002211, {16'h0000, adp});
    wr(IDX_CHOICE, 8'hFF);
    rd_chk("choice upper bits", IDX_CHOICE, 32'h00000001);
    chk_word("active ptr second", 32'h000012FF, {16'h0000, adp});
    // carry across the byte boundary lands on the second pointer only
    pulse(3'h4);
    repeat (2) @(posedge hclk);
    rd_chk("ptr b low inc", IDX_PTR_B_LO, 32'h00000000);
    rd_chk("ptr b high inc", IDX_PTR_B_HI, 32'h00000013);
    rd_chk("ptr a untouched", IDX_PTR_A_LO, 32'h00000011);
    pulse(3'h2);
    repeat (2) @(posedge hclk);
    rd_chk("choice toggled", IDX_CHOICE, 32'h00000000);
    chk_word("active ptr toggled", 32'h00002211, {16'h0000, adp});
    pulse(3'h2);
    repeat (2) @(posedge hclk);
    chk_word("active ptr back", 32'h00001300, {16'h0000, adp});
    // with the enable low a core increment must leave the pointers alone
    clk_en <= 1'b0;
    pulse(3'h4);
    repeat (2) @(posedge hclk);
    chk_word("frozen ptr", 32'h00001300, {16'h0000, adp});
    clk_en <= 1'b1;
    code_rd(q8);
    chk_word("guarded code byte", 32'h00000000, {24'h000000, q8});
    wr(IDX_PROTECT, 8'h00);
    rd_chk("protect not writable", IDX_PROTECT, 32'h00000001);
    mass_erase_done <= 1'b1;
    @(posedge hclk);
    mass_erase_done <= 1'b0;
    @(posedge hclk);
    code_rd(q8);
    chk_word("open code byte", 32'h000000A5, {24'h000000, q8});
    rd_chk("protect cleared", IDX_PROTECT, 32'h00000000);
    wr(8'h87, 8'h5A);
    rd_chk("unmapped", 8'h87, 32'h00000000);
    // a second reset in mid-run must restore the slow defaults
    do_reset();
    rd_chk("clkctl rereset", IDX_CLKCTL, 32'h00000001);
    rd_chk("protect rereset", IDX_PROTECT, 32'h00000001);
    rd_chk("ptr a rereset", IDX_PTR_A_LO, 32'h00000000);
    results();
  end
endmodule
